// ---- design/apmc_defines.vh ----
// constants for the power and miscellaneous command decoder
`ifndef APMC_DEFINES_VH
`define APMC_DEFINES_VH
// register byte offsets
`define APMC_OFF_FEAT      12'h000
`define APMC_OFF_SECCNT    12'h004
`define APMC_OFF_SECNUM    12'h008
`define APMC_OFF_CYLLO     12'h00c
`define APMC_OFF_CYLHI     12'h010
`define APMC_OFF_DRVHD     12'h014
`define APMC_OFF_CMD       12'h018
`define APMC_OFF_STATUS    12'h01c
`define APMC_OFF_ERROR     12'h020
`define APMC_OFF_MULT      12'h024
`define APMC_OFF_TIMER     12'h028
`define APMC_OFF_BUFWIN    12'h02c
`define APMC_OFF_IDW82     12'h030
`define APMC_OFF_IRQ       12'h034
// command codes
`define APMC_CMD_SETMULT   8'hc6
`define APMC_CMD_SLEEP_A   8'he6
`define APMC_CMD_SLEEP_B   8'h99
`define APMC_CMD_STBY_A    8'h96
`define APMC_CMD_STBY_B    8'he2
`define APMC_CMD_STBYI_A   8'h94
`define APMC_CMD_STBYI_B   8'he0
`define APMC_CMD_SMART     8'hb0
`define APMC_CMD_XLATE     8'h87
`define APMC_CMD_WRBUF     8'he8
// smart signature
`define APMC_SMART_CYLHI   8'hc2
`define APMC_SMART_CYLLO   8'h4f
`define APMC_SMART_DRVHD   3'h7
// status and error bits
`define APMC_ST_BUSY       7
`define APMC_ST_READY      6
`define APMC_ST_ERR        0
`define APMC_ST_DRQ        3
`define APMC_ER_ABORT      2
// supported block size limit
`define APMC_MAX_MULT      8'h10
// sector buffer: 512 bytes as 128 words
`define APMC_BUF_WORDS     8'h80
// sleep timer: 5 ms at 50 ns clock
`define APMC_SLEEP_MS      5
`define APMC_CLK_NS        50
// sized to the timer width; equals 5 ms divided by the 50 ns period
`define APMC_SLEEP_CYC     24'd100000
`endif

// ---- design/apmc_idle_timer.v ----
// idle timer that requests sleep after a quiet period
`timescale 1ns/1ns
`default_nettype none
module apmc_idle_timer #(
   parameter [23:0] PERIOD = 24'd100000
) (
   // clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // control
   input  wire        restart,
   input  wire        enable,
   // result
   output reg         expired
);
   reg [23:0] cnt_r;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r   <= 24'h000000;
         expired <= 1'b0;
      end else if (restart || !enable) begin
         cnt_r   <= 24'h000000;
         expired <= 1'b0;
      end else if (cnt_r == PERIOD - 24'd1) begin
         expired <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 24'd1;
      end
   end
endmodule
`default_nettype wire

// ---- design/apmc_core.v ----
// apb task-file command decoder for power and miscellaneous commands
//
// Function
// - Writing the set-multiple code raises busy and checks the sector count.
// - A supported nonzero block size is stored and enables multiple transfers.
// - An unsupported block size posts abort and disables multiple transfers.
// - A zero block size leaves multiple transfers disabled.
// - Multiple transfers are disabled after reset.
// - Either sleep code raises busy, enters sleep, drops busy and interrupts.
// - Any further command written wakes the device from sleep.
// - An idle timer of five milliseconds puts the device to sleep by itself.
// - Identify word 82 bit zero reports smart support.
// - Either standby code sleeps, drops busy and interrupts at once.
// - Either standby-immediate code sleeps, drops busy and interrupts at once.
// - Translate-sector raises no abort and leaves multiple transfers unchanged.
// - Translate-sector returns zero in the sector count.
// - Write-buffer takes exactly one 512-byte sector like write-sectors.
`timescale 1ns/1ns
`default_nettype none
`include "apmc_defines.vh"
module apmc_core #(
   parameter [23:0] SLEEP_CYCLES = `APMC_SLEEP_CYC
) (
   // apb clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // device state
   output reg         busy_flag,
   output reg         sleep_mode,
   output reg         intrq,
   output reg         mult_en
);
   //////////////////////////////////////////////////////////////////////////
   localparam ST_IDLE = 2'd0;
   localparam ST_EXEC = 2'd1;
   localparam ST_DATA = 2'd2;

   reg  [1:0]  state_r;
   reg  [7:0]  feat_r;
   reg  [7:0]  seccnt_r;
   reg  [7:0]  secnum_r;
   reg  [7:0]  cyllo_r;
   reg  [7:0]  cylhi_r;
   reg  [7:0]  drvhd_r;
   reg  [7:0]  cmd_r;
   reg  [7:0]  err_r;
   reg         errst_r;
   reg  [7:0]  mult_r;
   reg  [7:0]  wcnt_r;
   reg  [31:0] buf_mem [0:127];
   reg  [31:0] last_wr_r;
   reg         done_r;
   reg         sleep_en_r;
   reg         smart_ok_r;
   wire        idle_exp;

   wire        acc  = psel && penable;
   wire        wr   = acc && pwrite;
   wire        rd   = acc && !pwrite;
   wire        mapped = (paddr <= `APMC_OFF_IRQ) && (paddr[1:0] == 2'b00);
   wire        cmd_wr = wr && paddr == `APMC_OFF_CMD && !busy_flag;
   wire        buf_wr = wr && paddr == `APMC_OFF_BUFWIN && state_r == ST_DATA;
   // parameter registers are frozen while busy
   wire        par_wr = wr && !busy_flag;

   //////////////////////////////////////////////////////////////////////////
   // restart on completion
   apmc_idle_timer #(
      .PERIOD  (SLEEP_CYCLES)
   ) u_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .restart (done_r),
      .enable  (sleep_en_r && !sleep_mode && state_r == ST_IDLE),
      .expired (idle_exp)
   );

   //////////////////////////////////////////////////////////////////////////
   // apb slave: zero wait states, unmapped or misaligned gives pslverr
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         prdata  <= 32'h00000000;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               `APMC_OFF_FEAT:   prdata <= {24'h000000, feat_r};
               `APMC_OFF_SECCNT: prdata <= {24'h000000, seccnt_r};
               `APMC_OFF_SECNUM: prdata <= {24'h000000, secnum_r};
               `APMC_OFF_CYLLO:  prdata <= {24'h000000, cyllo_r};
               `APMC_OFF_CYLHI:  prdata <= {24'h000000, cylhi_r};
               `APMC_OFF_DRVHD:  prdata <= {24'h000000, drvhd_r};
               `APMC_OFF_CMD:    prdata <= {24'h000000, cmd_r};
               `APMC_OFF_STATUS: prdata <= {24'h000000, busy_flag, !busy_flag, 2'b00,
                                            state_r == ST_DATA, 2'b00, errst_r};
               `APMC_OFF_ERROR:  prdata <= {24'h000000, err_r};
               `APMC_OFF_MULT:   prdata <= {23'h000000, mult_en, mult_r};
               `APMC_OFF_TIMER:  prdata <= {30'h00000000, sleep_mode, sleep_en_r};
               `APMC_OFF_BUFWIN: prdata <= last_wr_r;
               `APMC_OFF_IDW82:  prdata <= {31'h00000000, 1'b1};
               `APMC_OFF_IRQ:    prdata <= {30'h00000000, smart_ok_r, intrq};
               default:          prdata <= 32'h00000000;
            endcase
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // task-file registers and command execution
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r    <= ST_IDLE;
         feat_r     <= 8'h00;
         seccnt_r   <= 8'h00;
         secnum_r   <= 8'h00;
         cyllo_r    <= 8'h00;
         cylhi_r    <= 8'h00;
         drvhd_r    <= 8'h00;
         cmd_r      <= 8'h00;
         err_r      <= 8'h00;
         errst_r    <= 1'b0;
         mult_r     <= 8'h00;
         mult_en    <= 1'b0;
         busy_flag  <= 1'b0;
         sleep_mode <= 1'b0;
         intrq      <= 1'b0;
         wcnt_r     <= 8'h00;
         last_wr_r  <= 32'h00000000;
         done_r     <= 1'b0;
         sleep_en_r <= 1'b1;
         smart_ok_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (par_wr) begin
            case (paddr)
               `APMC_OFF_FEAT:   feat_r   <= pwdata[7:0];
               `APMC_OFF_SECCNT: seccnt_r <= pwdata[7:0];
               `APMC_OFF_SECNUM: secnum_r <= pwdata[7:0];
               `APMC_OFF_CYLLO:  cyllo_r  <= pwdata[7:0];
               `APMC_OFF_CYLHI:  cylhi_r  <= pwdata[7:0];
               `APMC_OFF_DRVHD:  drvhd_r  <= pwdata[7:0];
               `APMC_OFF_TIMER:  sleep_en_r <= pwdata[0];
               default:          ;
            endcase
         end
         // reading the status register acknowledges the interrupt
         if (rd && paddr == `APMC_OFF_STATUS)
            intrq <= 1'b0;
         if (idle_exp && state_r == ST_IDLE)
            sleep_mode <= 1'b1;
         if (buf_wr) begin
            buf_mem[wcnt_r[6:0]] <= pwdata;
            last_wr_r <= pwdata;
         end
         case (state_r)
            ST_IDLE: begin
               if (cmd_wr) begin
                  cmd_r     <= pwdata[7:0];
                  busy_flag <= 1'b1;
                  intrq     <= 1'b0;
                  err_r     <= 8'h00;
                  errst_r   <= 1'b0;
                  sleep_mode <= 1'b0;
                  state_r   <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               busy_flag <= 1'b0;
               intrq     <= 1'b1;
               done_r    <= 1'b1;
               state_r   <= ST_IDLE;
               case (cmd_r)
                  `APMC_CMD_SETMULT: begin
                     if (seccnt_r == 8'h00) begin
                        mult_en <= 1'b0;
                     end else if (seccnt_r <= `APMC_MAX_MULT &&
                                  (seccnt_r & (seccnt_r - 8'h01)) == 8'h00) begin
                        mult_r  <= seccnt_r;
                        mult_en <= 1'b1;
                     end else begin
                        mult_en <= 1'b0;
                        err_r[`APMC_ER_ABORT] <= 1'b1;
                        errst_r <= 1'b1;
                     end
                  end
                  `APMC_CMD_SLEEP_A, `APMC_CMD_SLEEP_B,
                  `APMC_CMD_STBY_A, `APMC_CMD_STBY_B,
                  `APMC_CMD_STBYI_A, `APMC_CMD_STBYI_B:
                     sleep_mode <= 1'b1;
                  `APMC_CMD_SMART: begin
                     smart_ok_r <= cylhi_r == `APMC_SMART_CYLHI &&
                                   cyllo_r == `APMC_SMART_CYLLO &&
                                   drvhd_r[7:5] == `APMC_SMART_DRVHD;
                     if (!(cylhi_r == `APMC_SMART_CYLHI &&
                           cyllo_r == `APMC_SMART_CYLLO)) begin
                        err_r[`APMC_ER_ABORT] <= 1'b1;
                        errst_r <= 1'b1;
                     end
                  end
                  `APMC_CMD_XLATE:
                     seccnt_r <= 8'h00;
                  // enter data phase for one sector
                  `APMC_CMD_WRBUF: begin
                     busy_flag <= 1'b0;
                     intrq     <= 1'b0;
                     done_r    <= 1'b0;
                     wcnt_r    <= 8'h00;
                     state_r   <= ST_DATA;
                  end
                  default: begin
                     err_r[`APMC_ER_ABORT] <= 1'b1;
                     errst_r <= 1'b1;
                  end
               endcase
            end
            ST_DATA: begin
               if (buf_wr) begin
                  if (wcnt_r == `APMC_BUF_WORDS - 8'h01) begin
                     intrq   <= 1'b1;
                     done_r  <= 1'b1;
                     state_r <= ST_IDLE;
                  end
                  wcnt_r <= wcnt_r + 8'h01;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// ---- verification/apmc_core_properties.sv ----
// port assertions for the command decoder
`timescale 1ns/1ns
`default_nettype none
module apmc_core_checker #(
   parameter [23:0] SLEEP_CYCLES = 24'd100000
) (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // device state
   input wire logic        busy_flag,
   input wire logic        sleep_mode,
   input wire logic        intrq,
   input wire logic        mult_en
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic        acc;
   logic        cmdw;
   logic        armed_r;
   logic        wb_r;
   logic [24:0] idle_r;
   assign acc  = psel && penable;
   assign cmdw = acc && pwrite && paddr == 12'h018 && !busy_flag;
   ////////////////////////////////////////////////////////////////
   // idle count only after a completion; any bus access resets it, so it never runs ahead
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed_r <= 1'b0;
         wb_r    <= 1'b0;
         idle_r  <= 25'h0;
      end else begin
         if (cmdw)
            wb_r <= pwdata[7:0] == 8'he8;
         armed_r <= armed_r | busy_flag;
         idle_r  <= (psel || busy_flag || sleep_mode || !armed_r) ? 25'h0 : idle_r + 25'h1;
      end
   end
   ////////////////////////////////////////////////////////////////
   a_access_ready: assert property (acc |-> pready)
      else $error("access without ready");
   a_busy_pulse: assert property ($rose(busy_flag) |=> !busy_flag && (intrq != wb_r))
      else $error("busy not one cycle then interrupt");
   a_sleep_cmd: assert property (cmdw && pwdata[7:0] inside {8'he6, 8'h99}
      |=> busy_flag ##1 (sleep_mode && intrq))
      else $error("sleep command sequence wrong");
   a_stby_cmd: assert property (cmdw && pwdata[7:0] inside {8'h96, 8'he2}
      |=> busy_flag ##1 (sleep_mode && intrq))
      else $error("standby command sequence wrong");
   a_stbyi_cmd: assert property (cmdw && pwdata[7:0] inside {8'h94, 8'he0}
      |=> busy_flag ##1 (sleep_mode && intrq))
      else $error("standby immediate sequence wrong");
   a_wake_cmd: assert property (cmdw && sleep_mode && pwdata[7:0] == 8'h87
      |-> ##[1:2] !sleep_mode)
      else $error("command did not wake");
   a_sleep_holds: assert property (sleep_mode && !acc |=> sleep_mode)
      else $error("sleep left without command");
   a_mult_change: assert property (!$stable(mult_en) |-> $past(busy_flag))
      else $error("mult enable changed outside completion");
   a_xlate_noop: assert property (cmdw && pwdata[7:0] == 8'h87
      |-> ##2 mult_en == $past(mult_en, 2))
      else $error("translate changed mult enable");
   a_idle_bound: assert property (idle_r < {1'b0, SLEEP_CYCLES} + 25'd4)
      else $error("idle period passed without sleep");
endmodule
bind apmc_core apmc_core_checker #(.SLEEP_CYCLES(SLEEP_CYCLES)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .busy_flag(busy_flag), .sleep_mode(sleep_mode),
   .intrq(intrq), .mult_en(mult_en));
`default_nettype wire

// ---- verification/apmc_host.sv ----
// host model issuing task-file accesses over apb
`timescale 1ns/1ns
`default_nettype none
module apmc_host (
   // clock
   input  wire logic        pclk,
   // apb master
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   // device state
   input  wire logic        busy_flag
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
   end
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic e);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (!pready) @(posedge pclk);
         q = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         // released lines show garbage, not the last value
         paddr <= ~a;
         pwdata <= ~d;
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      begin
         xfer(1'b1, a, d, q, e);
      end
   endtask
   task rd(input logic [11:0] a, output logic [31:0] q, output logic e);
      begin
         xfer(1'b0, a, 32'h0, q, e);
      end
   endtask
   task cmd(input logic [7:0] c);
      begin
         while (busy_flag) @(posedge pclk);
         wr(12'h018, {24'h0, c});
      end
   endtask
   task smart(input logic [7:0] f);
      begin
         wr(12'h00c, 32'h4f);
         wr(12'h010, 32'hc2);
         wr(12'h014, 32'he0);
         wr(12'h000, {24'h0, f});
         cmd(8'hb0);
      end
   endtask
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// self-checking bench for the command decoder
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   localparam int SC = 50;
   logic        pclk;
   logic        presetn;
   wire         psel, penable, pwrite, pready, pslverr;
   wire         busy_flag, sleep_mode, intrq, mult_en;
   wire [11:0]  paddr;
   wire [31:0]  pwdata, prdata;
   int          error_cnt;
   int          n_checks;
   logic [31:0] q;
   logic        e;
   apmc_core #(.SLEEP_CYCLES(24'd50)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .busy_flag(busy_flag), .sleep_mode(sleep_mode),
      .intrq(intrq), .mult_en(mult_en));
   apmc_host i_host (
      .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .busy_flag(busy_flag));
   ////////////////////////////////////////////////////////////////
   task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      begin
         n_checks++;
         if (g !== x) begin
            $display("ERROR %s expected %h seen %h", nm, x, g);
            error_cnt++;
         end
      end
   endtask
   task settle(input int n);
      begin
         repeat (n) @(posedge pclk);
         @(negedge pclk);
      end
   endtask
   task tally_and_finish;
      begin
         if (error_cnt == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
         end else begin
            $display("Run complete: FAIL");
         end
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////////
   task t_reset;
      begin
         chk("mult_en", 0, mult_en);
         i_host.rd(12'h030, q, e);
         chk("word82 bit0", 1, q[0]);
         i_host.rd(12'h038, q, e);
         chk("unmapped slverr", 1, e);
      end
   endtask
   task t_setmult;
      logic [7:0] sz [4];
      begin
         sz = '{8'h04, 8'h03, 8'h00, 8'h10};
         foreach (sz[i]) begin
            i_host.wr(12'h004, {24'h0, sz[i]});
            i_host.cmd(8'hc6);
            settle(2);
            chk("mult_en", sz[i][2] | sz[i][4], mult_en);
            i_host.rd(12'h024, q, e);
            chk("mult reg en", sz[i][2] | sz[i][4], q[8]);
            i_host.rd(12'h020, q, e);
            if (sz[i] != 8'h00) chk("abort", sz[i] == 8'h03, q[2]);
         end
      end
   endtask
   task t_sleep;
      logic [7:0] cd [6];
      begin
         cd = '{8'he6, 8'h99, 8'h96, 8'he2, 8'h94, 8'he0};
         foreach (cd[i]) begin
            i_host.cmd(cd[i]);
            settle(2);
            chk("sleep", 1, sleep_mode);
            chk("intrq", 1, intrq);
            i_host.wr(12'h004, 32'h5a);
            i_host.cmd(8'h87);
            settle(2);
            chk("awake", 0, sleep_mode);
            chk("mult kept", 1, mult_en);
            i_host.rd(12'h004, q, e);
            chk("seccnt", 0, q[7:0]);
         end
      end
   endtask
   task t_idle;
      begin
         repeat (2) begin
            i_host.cmd(8'h87);
            settle(SC - 8);
            chk("early sleep", 0, sleep_mode);
         end
         settle(12);
         chk("idle sleep", 1, sleep_mode);
      end
   endtask
   task t_smart;
      begin
         i_host.smart(8'hd8);
         settle(2);
         i_host.rd(12'h034, q, e);
         chk("smart ok", 1, q[1]);
         i_host.rd(12'h020, q, e);
         chk("smart abort", 0, q[2]);
      end
   endtask
   task t_wrbuf;
      begin
         i_host.cmd(8'he8);
         settle(2);
         i_host.rd(12'h01c, q, e);
         chk("drq", 1, q[3]);
         for (int k = 0; k < 127; k++) i_host.wr(12'h02c, {4{k[7:0]}});
         settle(1);
         chk("early intrq", 0, intrq);
         i_host.wr(12'h02c, 32'ha5a5a5a5);
         settle(1);
         chk("buffer intrq", 1, intrq);
         i_host.rd(12'h01c, q, e);
         chk("drq done", 0, q[3]);
         i_host.wr(12'h02c, 32'h00000000);
         i_host.rd(12'h02c, q, e);
         chk("extra word", 32'ha5a5a5a5, q);
      end
   endtask
   task t_rerst;
      begin
         @(posedge pclk);
         presetn <= 1'b0;
         repeat (2) @(posedge pclk);
         presetn <= 1'b1;
         chk("mult_en rst", 0, mult_en);
         i_host.rd(12'h024, q, e);
         chk("mult reg rst", 0, q[8]);
      end
   endtask
   ////////////////////////////////////////////////////////////////
   always #25 pclk = ~pclk;
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      error_cnt = 0;
      n_checks = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_setmult;
      t_sleep;
      t_idle;
      t_smart;
      t_wrbuf;
      t_rerst;
      tally_and_finish;
   end
   // watchdog well beyond the expected several hundred cycles
   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
